// ===== logic/wdt_pkg.sv
// Constants shared by the windowed watchdog timer design
package wdt_pkg;

   // ****************************************************
   // Register map and data values
   // ****************************************************
   localparam logic [15:0] SVC_ADDR      = 16'hff99; // Service register
   localparam logic [7:0]  SVC_KEY       = 8'hac;    // Clear key
   localparam logic [7:0]  SVC_READ_RUN  = 8'h9a;    // Read value, enabled
   localparam logic [7:0]  SVC_READ_OFF  = 8'h1a;    // Read value, disabled
   localparam logic [7:0]  RDATA_RESET   = 8'h00;    // Read data at reset
   localparam logic [7:0]  OPT_RESET     = 8'h00;    // Option copy at reset

   // ****************************************************
   // Option byte field positions
   // ****************************************************
   localparam int OPT_LOCK_BIT = 0;   // Oscillator lock
   localparam int OPT_OVF_LSB  = 1;   // Overflow select, bits 3..1
   localparam int OPT_RUN_BIT  = 4;   // Run enable
   localparam int OPT_WIN_LSB  = 5;   // Window select, bits 6..5
   localparam int OVF_SEL_W    = 3;
   localparam int WIN_SEL_W    = 2;

   // ****************************************************
   // Counter geometry
   // ****************************************************
   localparam int          CNT_W       = 17;          // Up to 2^17 ticks
   localparam int          PER_W       = 18;          // Holds 2^17
   localparam logic [PER_W-1:0] PERIOD_BASE = 18'h00400; // 2^10 ticks
   localparam logic [PER_W-1:0] PERIOD_ONE  = 18'h00001;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 17'h00000;
   localparam logic [CNT_W-1:0] CNT_ONE     = 17'h00001;

   // Window codes: open quarter count is code plus one
   localparam logic [1:0] WIN_25  = 2'h0;
   localparam logic [1:0] WIN_50  = 2'h1;
   localparam logic [1:0] WIN_75  = 2'h2;

   // ****************************************************
   // Access checking
   // ****************************************************
   localparam logic [15:0] EXEMPT_BASE = 16'hfb00; // Data access exempt

   // Operating states of the watchdog
   typedef enum logic [1:0] {
      ST_LOAD,    // Capturing option byte after reset
      ST_OFF,     // Run enable clear, block idle
      ST_RUN,     // Counting and checking
      ST_FIRED    // Internal reset requested
   } wdt_state_e;

endpackage : wdt_pkg

// ===== logic/windowed_watchdog_timer.sv
// Windowed watchdog timer clocked by the low-speed oscillator
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps

module windowed_watchdog_timer
   import wdt_pkg::*;
(
   input  wire logic        clk_sys,           // System clock, 10 MHz
   input  wire logic        rst_b,             // Sync reset, active low
   input  wire logic [7:0]  opt_byte,          // Boot option byte
   input  wire logic        lowspeed_clk,      // Low-speed oscillator
   input  wire logic [15:0] addr,              // Register address
   input  wire logic [7:0]  wdata,             // Register write data
   input  wire logic        wr,                // Write strobe
   input  wire logic        rd,                // Read strobe
   input  wire logic        bit_op,            // Write is a 1-bit op
   output logic      [7:0]  rdata,             // Read data, cycle after rd
   input  wire logic        fetch_vld,         // Instruction fetch strobe
   input  wire logic [15:0] fetch_addr,        // Fetch address
   input  wire logic        data_vld,          // Data read/write strobe
   input  wire logic [15:0] data_addr,         // Data address
   input  wire logic [15:0] code_limit,        // From memory-size regs
   input  wire logic [15:0] ram_start,         // From memory-size regs
   input  wire logic        halt_mode,         // CPU in HALT
   input  wire logic        stop_mode,         // CPU in STOP
   input  wire logic        lowspeed_osc_stop, // Slow oscillator stop bit
   output logic             internal_reset,    // Reset request, held
   output logic             watchdog_reset_flag, // Reset cause flag
   output logic             window_open,       // Window state
   output logic             counting           // Counter advancing
);

   // ****************************************************
   // Declarations
   // ****************************************************
   wdt_state_e               state_r;
   wdt_state_e               state_nxt;
   logic [7:0]               opt_r;
   logic                     ls_s1_r;
   logic                     ls_s2_r;
   logic                     ls_s3_r;
   logic                     ls_filt_r;
   logic                     tick;
   logic [CNT_W-1:0]         cnt_r;
   logic                     first_done_r;
   logic                     err_pend_r;
   logic                     run_opt;
   logic                     lock_opt;
   logic [OVF_SEL_W-1:0]     ovf_sel;
   logic [WIN_SEL_W-1:0]     win_sel;
   logic [PER_W-1:0]         period;
   logic [PER_W-1:0]         period_last;
   logic [PER_W-1:0]         quarter;
   logic [PER_W-1:0]         close_lim;
   logic                     win_open;
   logic                     frozen;
   logic                     advance;
   logic                     svc_wr;
   logic                     key_bad;
   logic                     closed_wr;
   logic                     svc_err;
   logic                     svc_clear;
   logic                     at_last;
   logic                     overflow;
   logic                     fetch_bad;
   logic                     data_bad;
   logic                     access_err;
   logic                     fire;

   // ****************************************************
   // Option capture
   // ****************************************************
   // The option byte is a strap: it is latched in the first cycle after
   // reset release, never under reset itself
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         opt_r <= OPT_RESET;
      end else if (state_r == ST_LOAD) begin
         opt_r <= opt_byte;
      end
   end

   assign run_opt  = opt_r[OPT_RUN_BIT];
   assign lock_opt = opt_r[OPT_LOCK_BIT];
   assign ovf_sel  = opt_r[OPT_OVF_LSB +: OVF_SEL_W];
   assign win_sel  = opt_r[OPT_WIN_LSB +: WIN_SEL_W];

   // ****************************************************
   // Low-speed clock sampling
   // ****************************************************
   // Three stages; the level only changes once stages two and three agree,
   // which also rejects a single-cycle glitch on the oscillator pin
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ls_s1_r   <= 1'b0;
         ls_s2_r   <= 1'b0;
         ls_s3_r   <= 1'b0;
         ls_filt_r <= 1'b0;
      end else begin
         ls_s1_r <= lowspeed_clk;
         ls_s2_r <= ls_s1_r;
         ls_s3_r <= ls_s2_r;
         if (ls_s2_r == ls_s3_r) begin
            ls_filt_r <= ls_s3_r;
         end
      end
   end

   // One tick per rising edge of the filtered slow clock
   assign tick = (ls_s2_r == ls_s3_r) && ls_s3_r && !ls_filt_r;

   // ****************************************************
   // Period and window limits
   // ****************************************************
   // Period is 2^(10+code) slow ticks
   assign period      = PERIOD_BASE << ovf_sel;
   assign period_last = period - PERIOD_ONE;
   assign quarter     = period >> 2;

   // Closed span is the complement of the open fraction
   always_comb begin
      case (win_sel)
         WIN_25:  close_lim = quarter + (quarter << 1);
         WIN_50:  close_lim = quarter << 1;
         WIN_75:  close_lim = quarter;
         default: close_lim = '0;
      endcase
   end

   assign win_open = ({1'b0, cnt_r} >= close_lim);
   assign at_last  = ({1'b0, cnt_r} == period_last);

   // ****************************************************
   // Low-power freeze
   // ****************************************************
   // With the lock clear, HALT, STOP and oscillator stop all freeze the
   // count; flash self-programming has no input here and cannot stop it
   assign frozen  = !lock_opt
                    && (halt_mode || stop_mode || lowspeed_osc_stop);
   assign advance = (state_r == ST_RUN) && !frozen && tick;

   // ****************************************************
   // Service register decode
   // ****************************************************
   assign svc_wr    = wr && (addr == SVC_ADDR) && (state_r == ST_RUN);
   assign key_bad   = bit_op || (wdata != SVC_KEY);
   // The first write after reset is accepted anywhere before overflow
   assign closed_wr = first_done_r && !win_open;
   assign svc_err   = svc_wr && (key_bad || closed_wr);
   assign svc_clear = svc_wr && !key_bad && !closed_wr;

   // A clear in the same cycle as the terminal tick wins over overflow
   assign overflow  = advance && at_last && !svc_clear;

   // ****************************************************
   // Illegal access detection
   // ****************************************************
   assign fetch_bad = fetch_vld && (fetch_addr >= code_limit)
                      && (fetch_addr < ram_start);
   assign data_bad  = data_vld && (data_addr >= code_limit)
                      && (data_addr < ram_start)
                      && (data_addr < EXEMPT_BASE);
   assign access_err = (state_r == ST_RUN) && (fetch_bad || data_bad);

   // Service errors found while the slow clock is frozen are held until
   // it runs again; access errors and overflow act at once
   assign fire = (state_r == ST_RUN)
                 && (overflow || access_err
                     || (!frozen && (svc_err || err_pend_r)));

   // ****************************************************
   // State machine
   // ****************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_LOAD: begin
            // Counting begins without any software action
            if (opt_byte[OPT_RUN_BIT]) begin
               state_nxt = ST_RUN;
            end else begin
               state_nxt = ST_OFF;
            end
         end
         ST_OFF: begin
            state_nxt = ST_OFF;
         end
         ST_RUN: begin
            if (fire) begin
               state_nxt = ST_FIRED;
            end
         end
         ST_FIRED: begin
            state_nxt = ST_FIRED;                            // Wait reset
         end
         default: begin
            state_nxt = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_r <= ST_LOAD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************
   // Counter
   // ****************************************************
   // The clear acts on the system clock while the tick phase is kept,
   // so the next period may be short by up to one slow tick
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_r <= CNT_ZERO;
      end else if (svc_clear) begin
         cnt_r <= CNT_ZERO;
      end else if (advance && !at_last) begin
         cnt_r <= cnt_r + CNT_ONE;
      end
   end

   // First service write seen after reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         first_done_r <= 1'b0;
      end else if (svc_wr) begin
         first_done_r <= 1'b1;
      end
   end

   // Service error parked while frozen
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         err_pend_r <= 1'b0;
      end else if (svc_err && frozen) begin
         err_pend_r <= 1'b1;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   // Reset request and cause flag hold until the system reset clears us
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         internal_reset      <= 1'b0;
         watchdog_reset_flag <= 1'b0;
      end else if (fire) begin
         internal_reset      <= 1'b1;
         watchdog_reset_flag <= 1'b1;
      end
   end

   // Status outputs for observation
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         window_open <= 1'b0;
         counting    <= 1'b0;
      end else begin
         window_open <= (state_r == ST_RUN) && win_open;
         counting    <= (state_r == ST_RUN) && !frozen;
      end
   end

   // Read port: the key never reads back; unmapped addresses read zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdata <= RDATA_RESET;
      end else if (rd && (addr == SVC_ADDR)) begin
         rdata <= run_opt ? SVC_READ_RUN : SVC_READ_OFF;
      end else begin
         rdata <= RDATA_RESET;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   a_off_quiet: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_OFF) |-> !internal_reset && !counting)
      else $error("Disabled watchdog requested a reset");

   a_auto_start: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_LOAD) && opt_byte[OPT_RUN_BIT] |=> state_r == ST_RUN)
      else $error("Enabled watchdog did not start");

   a_key_clears: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      svc_wr && !bit_op && wdata == SVC_KEY && win_open
      && !access_err && !err_pend_r
      |=> cnt_r == CNT_ZERO && !internal_reset)
      else $error("Key write in open window did not clear");

   a_first_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      svc_wr && !first_done_r && !bit_op && wdata == SVC_KEY
      && !access_err |=> cnt_r == CNT_ZERO && !internal_reset)
      else $error("First key write did not clear");

   a_closed_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      svc_wr && first_done_r && !win_open && !frozen
      |=> internal_reset && watchdog_reset_flag)
      else $error("Closed window write missed reset");

   a_overflow_rst: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      advance && at_last && !svc_wr |=> internal_reset)
      else $error("Overflow did not raise reset");

   a_bad_key: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      svc_wr && wdata != SVC_KEY |=> internal_reset || err_pend_r)
      else $error("Wrong key did not raise reset");

   a_bit_op: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      svc_wr && bit_op |=> internal_reset || err_pend_r)
      else $error("Bit operation did not raise reset");

   // A parked service error must act as soon as the freeze lifts
   a_parked_fire: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      state_r == ST_RUN && err_pend_r && !frozen |=> internal_reset)
      else $error("Parked service error did not fire");

   a_fetch_check: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      state_r == ST_RUN && fetch_bad |=> internal_reset)
      else $error("Illegal fetch did not raise reset");

   a_exempt_data: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      state_r == ST_RUN && data_vld && data_addr >= EXEMPT_BASE
      && !fetch_vld && !wr && !advance && !err_pend_r
      |=> !internal_reset || $past(internal_reset))
      else $error("Exempt access raised reset");

   a_freeze_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      frozen && !svc_wr |=> $stable(cnt_r))
      else $error("Counter moved while frozen");

   a_read_value: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      rd && addr == SVC_ADDR
      |=> rdata == (run_opt ? SVC_READ_RUN : SVC_READ_OFF))
      else $error("Service register read value wrong");

endmodule : windowed_watchdog_timer

// ===== tb/testbench.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps

`define CHK(what, exp, got) \
   begin \
      checks_done = checks_done + 1; \
      if ((got) !== (exp)) begin \
         mismatches = mismatches + 1; \
         $display("ERROR %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module testbench
   import wdt_pkg::*;
;
   // ***********************************************
   // Stimulus, observed outputs and the design
   // ***********************************************
   logic        clk_sys = 1'b0, rst_b = 1'b0, lowspeed_clk = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, bit_op = 1'b0, osc_run = 1'b1;
   logic        fetch_vld = 1'b0, data_vld = 1'b0;
   logic        halt_mode = 1'b0, stop_mode = 1'b0;
   logic        lowspeed_osc_stop = 1'b0;
   logic [7:0]  opt_byte = 8'h00, wdata = 8'h00, rdata, rv;
   logic [15:0] addr = 16'h0000, fetch_addr = 16'h0000;
   logic [15:0] data_addr = 16'h0000;
   logic [15:0] code_limit = 16'h8000, ram_start = 16'hfc00;
   logic        internal_reset, watchdog_reset_flag, window_open, counting;
   int          mismatches = 0, checks_done = 0, n, e;

   windowed_watchdog_timer uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .opt_byte(opt_byte),
      .lowspeed_clk(lowspeed_clk), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .bit_op(bit_op), .rdata(rdata),
      .fetch_vld(fetch_vld), .fetch_addr(fetch_addr),
      .data_vld(data_vld), .data_addr(data_addr),
      .code_limit(code_limit), .ram_start(ram_start),
      .halt_mode(halt_mode), .stop_mode(stop_mode),
      .lowspeed_osc_stop(lowspeed_osc_stop),
      .internal_reset(internal_reset),
      .watchdog_reset_flag(watchdog_reset_flag),
      .window_open(window_open), .counting(counting)
   );

   // System clock, 100 ns period
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   // Slow clock, 8 system cycles; odd offset keeps edges apart
   initial begin
      #137;
      forever #400 if (osc_run) lowspeed_clk = ~lowspeed_clk;
   end

   // ***********************************************
   // Access tasks and helpers
   // ***********************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // Packs window, run, overflow and lock codes into the option byte
   function automatic logic [7:0] mk_opt(input logic [1:0] w,
      input logic run, input logic [2:0] s, input logic lk);
      return {1'b0, w, run, s, lk};
   endfunction : mk_opt

   // Collapses a tick count inside tolerance onto the expectation
   function automatic int snap(input int ex, input int got, input int tol);
      return (got >= ex - tol && got <= ex + tol) ? ex : got;
   endfunction : snap

   task automatic do_reset(input logic [7:0] opt);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      opt_byte <= opt;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask : do_reset

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d,
                         input logic bo);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      bit_op <= bo;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      bit_op <= 1'b0;
   endtask : wr_reg

   // Read data are taken only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic access(input logic is_fetch, input logic [15:0] a);
      @(posedge clk_sys);
      fetch_addr <= a;
      data_addr <= a;
      fetch_vld <= is_fetch;
      data_vld <= !is_fetch;
      @(posedge clk_sys);
      fetch_vld <= 1'b0;
      data_vld <= 1'b0;
   endtask : access

   task automatic set_freeze(input logic h, input logic s, input logic o);
      @(posedge clk_sys);
      halt_mode <= h;
      stop_mode <= s;
      lowspeed_osc_stop <= o;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : set_freeze

   task automatic ticks(input int k);
      repeat (k) @(posedge lowspeed_clk);
   endtask : ticks

   // Counts slow edges until the chosen output rises, bounded
   task automatic ticks_until(input logic want_rst, input int lim,
                              output int cnt);
      cnt = 0;
      while ((want_rst ? internal_reset : window_open) !== 1'b1) begin
         if (cnt >= lim) begin
            $display("ERROR wait expected rise seen none");
            mismatches = mismatches + 1;
            tally_and_finish();
         end else begin
            @(posedge lowspeed_clk);
            cnt = cnt + 1;
         end
      end
   endtask : ticks_until

   // ***********************************************
   // Test sequence
   // ***********************************************
   initial begin
      // Disabled block: fixed read value, no counting, no checks
      do_reset(mk_opt(2'h3, 1'b0, 3'h0, 1'b0));
      rd_reg(SVC_ADDR, rv);
      `CHK("read off", SVC_READ_OFF, rv)
      wr_reg(SVC_ADDR, 8'h55, 1'b0);
      access(1'b1, 16'h9000);
      ticks(4);
      `CHK("off counting", 1'b0, counting)
      `CHK("off reset", 1'b0, internal_reset)
      $display("test disabled done");

      // Enabled block reads its fixed value, never the key
      do_reset(mk_opt(2'h3, 1'b1, 3'h0, 1'b0));
      rd_reg(SVC_ADDR, rv);
      `CHK("read run", SVC_READ_RUN, rv)
      wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
      rd_reg(SVC_ADDR, rv);
      `CHK("read after key", SVC_READ_RUN, rv)
      rd_reg(16'hff98, rv);
      `CHK("unmapped read", 8'h00, rv)
      ticks(3);
      `CHK("auto start", 1'b1, counting)
      $display("test reads done");

      // Error table: bit i of the vector says a reset is due
      for (int i = 0; i < 8; i++) begin
         do_reset(mk_opt(2'h3, i != 7, 3'h0, 1'b0));
         wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
         case (i)
            0: wr_reg(SVC_ADDR, 8'h55, 1'b0);
            1: wr_reg(SVC_ADDR, SVC_KEY, 1'b1);
            2: access(1'b1, 16'h9000);
            3: access(1'b0, 16'h9000);
            4: access(1'b0, 16'hfb10);
            5: access(1'b1, 16'hfb10);
            6: access(1'b1, 16'h0100);
            default: access(1'b0, 16'h9000);
         endcase
         repeat (2) @(posedge clk_sys);
         #1;
         e = (8'h2f >> i) & 1;
         `CHK("error reset", e[0], internal_reset)
         `CHK("reset flag", e[0], watchdog_reset_flag)
      end
      $display("test errors done");

      // Each window: first write anywhere, open clear, then a write that is closed below code 3
      for (int w = 0; w < 4; w++) begin
         do_reset(mk_opt(w[1:0], 1'b1, 3'h1, 1'b0));
         ticks(20);
         wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
         ticks_until(1'b0, 4096, n);
         e = 2048 * (3 - w) / 4;
         `CHK("open ticks", e, snap(e, n, 2))
         `CHK("first write", 1'b0, internal_reset)
         wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK("cleared", w == 3, window_open)
         `CHK("open write", 1'b0, internal_reset)
         wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK("closed write", w != 3, internal_reset)
      end
      $display("test windows done");

      // Overflow after the selected period with no service
      for (int s = 0; s < 2; s++) begin
         do_reset(mk_opt(2'h3, 1'b1, s[2:0], 1'b0));
         ticks_until(1'b1, 8192, n);
         e = 1024 << s;
         `CHK("overflow ticks", e, snap(e, n, 2))
         `CHK("overflow flag", 1'b1, watchdog_reset_flag)
      end
      $display("test overflow done");

      // Late key near terminal count, then slow clock held still
      do_reset(mk_opt(2'h3, 1'b1, 3'h0, 1'b0));
      wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
      ticks(1020);
      wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
      osc_run = 1'b0;
      repeat (3000) @(posedge clk_sys);
      osc_run = 1'b1;
      ticks(600);
      `CHK("late key", 1'b0, internal_reset)
      $display("test late key done");

      // Freezing with lock clear keeps the count; lock set ignores it
      do_reset(mk_opt(2'h2, 1'b1, 3'h0, 1'b0));
      wr_reg(SVC_ADDR, SVC_KEY, 1'b0);
      ticks(100);
      set_freeze(1'b1, 1'b0, 1'b0);
      `CHK("halt counting", 1'b0, counting)
      ticks(200);
      `CHK("halt window", 1'b0, window_open)
      set_freeze(1'b0, 1'b0, 1'b0);
      ticks_until(1'b0, 1024, n);
      `CHK("resume ticks", 156, snap(156, n, 3))
      set_freeze(1'b0, 1'b1, 1'b0);
      `CHK("stop counting", 1'b0, counting)
      set_freeze(1'b0, 1'b0, 1'b1);
      `CHK("osc stop counting", 1'b0, counting)
      set_freeze(1'b0, 1'b0, 1'b0);
      // A bad key while halted is held until the slow clock runs again
      set_freeze(1'b1, 1'b0, 1'b0);
      wr_reg(SVC_ADDR, 8'h55, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("parked hold", 1'b0, internal_reset)
      set_freeze(1'b0, 1'b0, 1'b0);
      `CHK("parked fire", 1'b1, internal_reset)
      `CHK("parked flag", 1'b1, watchdog_reset_flag)
      do_reset(mk_opt(2'h2, 1'b1, 3'h0, 1'b1));
      set_freeze(1'b1, 1'b1, 1'b1);
      `CHK("lock counting", 1'b1, counting)
      set_freeze(1'b0, 1'b0, 1'b0);
      $display("test freeze done");
      tally_and_finish();
   end

endmodule : testbench
